// file: verilog/fpad_pkg.sv
package fpad_pkg;

	//////////////////////////////////////////////////////////////////////////
	// Register bus and map (byte addresses, one word each)
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int NUM_OUT = 8;
	localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h04;
	localparam logic [ADDR_W-1:0] ADDR_CLK_BASE = 8'h40;
	localparam logic [ADDR_W-1:0] ADDR_REF_BASE = 8'h80;
	localparam logic [ADDR_W-1:0] ADDR_BANK_MASK = 8'he0;
	localparam int IDX_LSB = 2;
	localparam int IDX_W = 3;

	// Control and status bits
	localparam int CTRL_REQ_BIT = 0;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_REQ_BIT = 1;

	// Common output field positions
	localparam int F_PD = 0;
	localparam int F_HCSL = 1;
	localparam int F_STYLE = 2;
	localparam int F_EN = 3;
	localparam int F_AMP_LSB = 4;
	// Clock output fields
	localparam int F_DIV_LSB = 8;
	localparam int F_CPH_LSB = 16;
	// SYSREF-capable output fields
	localparam int F_SRC = 6;
	localparam int F_RPH_LSB = 8;

	// Field widths
	localparam int DIV_CODE_W = 4;
	localparam int CPH_W = 8;
	localparam int RPH_W = 3;
	localparam int RATIO_W = 5;
	localparam int AMP_MV_W = 11;

	// Reset values: clock outputs on as LVDS 350 mV, SYSREF outputs disabled
	localparam logic [DATA_W-1:0] CLK_CFG_RST = 32'h0000_0008;
	localparam logic [DATA_W-1:0] REF_CFG_RST = 32'h0000_0040;

	// Alignment length in input clock periods, and the ahead-of-clock limit
	localparam int ALIGN_CYCLES = 48;
	localparam logic [RPH_W-1:0] REF_LEAD_MAX = 3'h3;

	// Amplitudes in mV, single-ended
	localparam logic [AMP_MV_W-1:0] AMP_350 = 11'h15e;
	localparam logic [AMP_MV_W-1:0] AMP_500 = 11'h1f4;
	localparam logic [AMP_MV_W-1:0] AMP_750 = 11'h2ee;
	localparam logic [AMP_MV_W-1:0] AMP_1000 = 11'h3e8;

	typedef enum logic [1:0] {
		FPAD_OFF = 2'h0,
		FPAD_LVDS = 2'h1,
		FPAD_LVPECL = 2'h2,
		FPAD_HCSL = 2'h3
	} fpad_mode_e;

	typedef enum logic [1:0] {
		FPAD_IDLE = 2'h0,
		FPAD_WAIT = 2'h1,
		FPAD_ALIGN = 2'h3
	} fpad_state_e;

	// One differential output as seen at the pins
	typedef struct packed {
		logic on;
		fpad_mode_e mode;
		logic [AMP_MV_W-1:0] amp_mv;
		logic ref_lead;
		logic q;
		logic qn;
	} fpad_drive_s;

	// Divider code to ratio: 1,2,3,4,6,8,12,16,24; unknown codes divide by 1
	function automatic logic [RATIO_W-1:0] fpad_ratio(input logic [DIV_CODE_W-1:0] code);
		logic [RATIO_W-1:0] r;
		r = 5'h01;
		case (code)
			4'h1: r = 5'h02;
			4'h2: r = 5'h03;
			4'h3: r = 5'h04;
			4'h4: r = 5'h06;
			4'h5: r = 5'h08;
			4'h6: r = 5'h0c;
			4'h7: r = 5'h10;
			4'h8: r = 5'h18;
			default: r = 5'h01;
		endcase
		return r;
	endfunction : fpad_ratio

endpackage : fpad_pkg

// file: verilog/fpad_div_chan.sv
`timescale 1ns/10ps
// One output divider: emits a one-cycle pulse on each rising incident edge.
module fpad_div_chan
	import fpad_pkg::*;
#(
	parameter int RW = RATIO_W,
	parameter int DW = CPH_W
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Setup
	input wire logic [RW-1:0] ratio_i,
	input wire logic [DW-1:0] delay_i,
	// Alignment control
	input wire logic stretch_i,
	input wire logic restart_i,
	// Edge pulse
	output logic tick_o
);

	logic [RW-1:0] cnt_reg;
	logic [DW-1:0] dly_reg;
	logic held_reg;
	logic div1;
	logic term;

	assign div1 = (ratio_i == RW'(1));
	// A shrunk ratio may leave the count beyond the end, so compare with >=
	assign term = (cnt_reg >= ratio_i - RW'(1));

	// Period counter with stretch and common restart
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_reg <= '0;
			dly_reg <= '0;
			held_reg <= 1'b0;
		end else if (div1) begin
			cnt_reg <= '0;
			dly_reg <= '0;
			held_reg <= 1'b0;
		end else if (restart_i) begin
			cnt_reg <= '0;
			dly_reg <= delay_i;
			held_reg <= 1'b0;
		end else if (dly_reg != '0) begin
			dly_reg <= dly_reg - DW'(1);
		end else if (term) begin
			if (stretch_i && !held_reg) begin
				held_reg <= 1'b1;
			end else begin
				cnt_reg <= '0;
				held_reg <= 1'b0;
			end
		end else begin
			cnt_reg <= cnt_reg + RW'(1);
		end
	end

	// Edge pulse; fixed one-cycle latency whatever the ratio
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			tick_o <= 1'b0;
		end else begin
			tick_o <= div1 || (!restart_i && dly_reg == '0 && cnt_reg == '0);
		end
	end

endmodule : fpad_div_chan

// file: verilog/fpad_align_top.sv
`timescale 1ns/10ps
module fpad_align_top
	import fpad_pkg::*;
#(
	parameter int N_OUT = NUM_OUT,
	parameter int ALIGN_LEN = ALIGN_CYCLES
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Register port
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic [DATA_W-1:0] wr_data_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [DATA_W-1:0] rd_data_o,
	// Reference input
	input wire logic ref_i,
	// Outputs
	output fpad_drive_s [N_OUT-1:0] fanout_clock_output_o,
	output fpad_drive_s [N_OUT-1:0] sysref_capable_output_o,
	output logic align_busy_status_o
);

	//////////////////////////////////////////////////////////////////////////
	// Declarations
	// Alignment counter wide enough for whatever length is chosen
	localparam int CNT_W = $clog2(ALIGN_LEN + 1);
	// Configuration words, one per output index
	logic [DATA_W-1:0] clk_cfg_reg [N_OUT];
	logic [DATA_W-1:0] ref_cfg_reg [N_OUT];
	// Request, status and sequencer
	logic multi_device_align_request_reg;
	logic align_busy_status_reg;
	fpad_state_e state_reg;
	fpad_state_e state_next;
	logic [CNT_W-1:0] align_cnt_reg;
	// Reference edge detect
	logic ref_d1_reg;
	logic ref_d2_reg;
	logic ref_rise;
	// Sequencer strobes to the dividers
	logic align_done;
	logic restart;
	logic stretch;
	// Register decode
	logic wr_ctrl;
	logic [IDX_W-1:0] idx;
	// Incident-edge pulses from the dividers
	logic [N_OUT-1:0] tick;

	assign idx = addr_i[IDX_LSB +: IDX_W];
	assign wr_ctrl = wr_i && addr_i == ADDR_CTRL && wr_data_i[CTRL_REQ_BIT];

	//////////////////////////////////////////////////////////////////////////
	// Reference sampling
	// Two samples so the edge test compares the newest level with the one before
	// The reference idles low, so both samples reset low and no false rise follows
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ref_d1_reg <= 1'b0;
			ref_d2_reg <= 1'b0;
		end else begin
			ref_d1_reg <= ref_i;
			ref_d2_reg <= ref_d1_reg;
		end
	end

	assign ref_rise = ref_d1_reg && !ref_d2_reg;

	//////////////////////////////////////////////////////////////////////////
	// Alignment sequencer
	// A rise seen while idle is dropped; only an armed request waits for one
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			FPAD_IDLE: begin
				if (multi_device_align_request_reg) begin
					state_next = FPAD_WAIT;
				end
			end
			FPAD_WAIT: begin
				if (ref_rise) begin
					state_next = FPAD_ALIGN;
				end
			end
			FPAD_ALIGN: begin
				// Later rises during alignment are ignored
				if (align_done) begin
					state_next = FPAD_IDLE;
				end
			end
			default: state_next = FPAD_IDLE;
		endcase
	end

	// Sequencer state
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_reg <= FPAD_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// Fixed-length alignment so duration never depends on the chosen ratios
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			align_cnt_reg <= '0;
		end else if (state_reg == FPAD_ALIGN) begin
			align_cnt_reg <= align_cnt_reg + CNT_W'(1);
		end else begin
			align_cnt_reg <= '0;
		end
	end

	// The last counted cycle restarts every divided channel (ratio 1 ignores restart) and clears the request
	assign align_done = (state_reg == FPAD_ALIGN) &&
		(align_cnt_reg == CNT_W'(ALIGN_LEN - 1));
	assign restart = align_done;
	// Stretch reaches every divided channel at once so they keep step
	assign stretch = (state_reg == FPAD_ALIGN);

	// Request bit: a new write wins over the self-clear in the same cycle
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			multi_device_align_request_reg <= 1'b0;
		end else if (wr_ctrl) begin
			multi_device_align_request_reg <= 1'b1;
		end else if (align_done) begin
			multi_device_align_request_reg <= 1'b0;
		end
	end

	// Busy status follows the request through wait and alignment
	// Busy rises with the request, so software sees it before the state moves
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			align_busy_status_reg <= 1'b0;
		end else if (wr_ctrl) begin
			align_busy_status_reg <= 1'b1;
		end else if (align_done) begin
			align_busy_status_reg <= 1'b0;
		end
	end

	assign align_busy_status_o = align_busy_status_reg;

	//////////////////////////////////////////////////////////////////////////
	// Configuration registers
	// Control and status words lie outside both banks and are not touched here
	// A ratio change acts at once; a new clock delay waits for the next restart
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			for (int i = 0; i < N_OUT; i++) begin
				clk_cfg_reg[i] <= CLK_CFG_RST;
				ref_cfg_reg[i] <= REF_CFG_RST;
			end
		end else if (wr_i) begin
			if ((addr_i & ADDR_BANK_MASK) == ADDR_CLK_BASE) begin
				clk_cfg_reg[idx] <= wr_data_i;
			end else if ((addr_i & ADDR_BANK_MASK) == ADDR_REF_BASE) begin
				ref_cfg_reg[idx] <= wr_data_i;
			end
		end
	end

	// Read data, one cycle after the strobe; unmapped reads as zero
	// Returning zero between reads keeps a stale word from looking valid
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rd_data_o <= '0;
		end else if (rd_i) begin
			if (addr_i == ADDR_CTRL) begin
				rd_data_o <= DATA_W'(multi_device_align_request_reg);
			end else if (addr_i == ADDR_STATUS) begin
				rd_data_o <= '0;
				rd_data_o[STAT_BUSY_BIT] <= align_busy_status_reg;
				rd_data_o[STAT_REQ_BIT] <= multi_device_align_request_reg;
			end else if ((addr_i & ADDR_BANK_MASK) == ADDR_CLK_BASE) begin
				rd_data_o <= clk_cfg_reg[idx];
			end else if ((addr_i & ADDR_BANK_MASK) == ADDR_REF_BASE) begin
				rd_data_o <= ref_cfg_reg[idx];
			end else begin
				rd_data_o <= '0;
			end
		end else begin
			rd_data_o <= '0;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Dividers, one per output index
	// All channels share one stretch and one restart, which keeps them in phase
	for (genvar g = 0; g < N_OUT; g++) begin : g_chan
		fpad_div_chan #(
			.RW(RATIO_W),
			.DW(CPH_W)
		) u_chan (
			.clk_i(clk_i),
			.rst_i(rst_i),
			.ratio_i(fpad_ratio(clk_cfg_reg[g][F_DIV_LSB +: DIV_CODE_W])),
			.delay_i(clk_cfg_reg[g][F_CPH_LSB +: CPH_W]),
			.stretch_i(stretch),
			.restart_i(restart),
			.tick_o(tick[g])
		);
	end

	//////////////////////////////////////////////////////////////////////////
	// Output style decode
	function automatic fpad_drive_s drive(input logic [DATA_W-1:0] cfg, input logic sig);
		fpad_drive_s d;
		logic [1:0] amp;
		d = '0;
		amp = cfg[F_AMP_LSB +: 2];
		// Power-down wins over every other field except the SYSREF phase, which still sets ref_lead
		if (cfg[F_PD]) begin
			d.on = 1'b0;
			d.mode = FPAD_OFF;
			d.amp_mv = '0;
			d.q = 1'b0;
			d.qn = 1'b0;
		end else begin
			d.on = 1'b1;
			// HCSL needs both style bits; the HCSL bit alone falls back to LVDS
			if (cfg[F_HCSL] && cfg[F_STYLE]) begin
				d.mode = FPAD_HCSL;
				d.amp_mv = AMP_500;
			end else if (cfg[F_STYLE]) begin
				d.mode = FPAD_LVPECL;
				d.amp_mv = (amp == 2'h0) ? AMP_350 : (amp == 2'h1) ? AMP_750 : AMP_1000;
			end else begin
				d.mode = FPAD_LVDS;
				d.amp_mv = (amp == 2'h0) ? AMP_350 : AMP_750;
			end
			// A disabled output carries no amplitude
			if (!cfg[F_EN]) begin
				d.amp_mv = '0;
			end
			// Disabled outputs rest at static low
			d.q = cfg[F_EN] && sig;
			d.qn = !(cfg[F_EN] && sig);
		end
		return d;
	endfunction : drive

	// Clock outputs
	// Registered so every pin changes on one edge, whatever the decode depth
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			fanout_clock_output_o <= '0;
		end else begin
			for (int i = 0; i < N_OUT; i++) begin
				fanout_clock_output_o[i] <= drive(clk_cfg_reg[i], tick[i]);
			end
		end
	end

	// SYSREF-capable outputs; the reference passes whatever the sequencer does
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			sysref_capable_output_o <= '0;
		end else begin
			for (int i = 0; i < N_OUT; i++) begin
				if (ref_cfg_reg[i][F_SRC]) begin
					sysref_capable_output_o[i] <= drive(ref_cfg_reg[i], ref_d1_reg);
					// Lead flag stands in for the sub-cycle delay, which is not modelled
					sysref_capable_output_o[i].ref_lead <=
						(ref_cfg_reg[i][F_RPH_LSB +: RPH_W] <= REF_LEAD_MAX);
				end else begin
					sysref_capable_output_o[i] <= drive(ref_cfg_reg[i], tick[i]);
				end
			end
		end
	end

endmodule : fpad_align_top

// file: tb/fpad_ref_src.sv
`timescale 1ns/10ps
// Upstream generator: one long reference pulse per go request
module fpad_ref_src #(
	parameter int WAIT = 500,
	parameter int HI = 20
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Command and reference line
	input wire logic go_i,
	output logic ref_o
);
	int cnt;

	// Quiet settle time after arming, then a pulse far slower than any output
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt <= 0;
			ref_o <= 1'b0;
		end else if (go_i) begin
			cnt <= WAIT + HI;
		end else if (cnt != 0) begin
			cnt <= cnt - 1;
			ref_o <= (cnt <= HI);
		end else begin
			ref_o <= 1'b0;
		end
	end
endmodule : fpad_ref_src

// file: tb/fpad_align_top_chk.sv
`timescale 1ns/10ps
module fpad_align_top_chk
	import fpad_pkg::*;
#(
	parameter int N_OUT = NUM_OUT,
	parameter int ALIGN_LEN = ALIGN_CYCLES
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Register port
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic [DATA_W-1:0] wr_data_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [DATA_W-1:0] rd_data_o,
	// Reference and outputs
	input wire logic ref_i,
	input wire fpad_drive_s [N_OUT-1:0] fanout_clock_output_o,
	input wire fpad_drive_s [N_OUT-1:0] sysref_capable_output_o,
	input wire logic align_busy_status_o
);
	localparam int LAST = ALIGN_LEN + 1;
	fpad_drive_s [N_OUT-1:0] fo;
	fpad_drive_s [N_OUT-1:0] so;
	logic busy, bq, rq, start, wr1;
	int cnt;

	// Short aliases
	assign fo = fanout_clock_output_o;
	assign so = sysref_capable_output_o;
	assign busy = align_busy_status_o;
	assign wr1 = wr_i && addr_i == ADDR_CLK_BASE + 8'h04;
	assign start = busy && bq && ref_i && !rq && cnt == 0;

	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// Lock out later rises so only the starting edge is timed
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			bq <= 1'b0;
			rq <= 1'b0;
			cnt <= 0;
		end else begin
			bq <= busy;
			rq <= ref_i;
			if (cnt != 0) cnt <= cnt - 1;
			else if (start) cnt <= LAST + 1;
		end
	end

	sequence s_done;
		busy ##1 !busy;
	endsequence

	////////////////////////////////////////
	AST_BUSY_SET:
		assert property (wr_i && addr_i == ADDR_CTRL && wr_data_i[CTRL_REQ_BIT] |=> busy)
		else $error("busy not raised by request");
	AST_ALIGN_LEN:
		assert property (start |-> ##LAST s_done)
		else $error("alignment length wrong");
	AST_REF_PASS:
		assert property (so[3].ref_lead && so[3].amp_mv != 0 |-> so[3].q == $past(ref_i, 2))
		else $error("reference not passed through");
	AST_PD_OFF:
		assert property (wr1 && wr_data_i[F_PD] |-> ##2 !fo[1].on && fo[1].amp_mv == 0)
		else $error("powered-down output still on");
	AST_HCSL:
		assert property (wr1 && wr_data_i[3:0] == 4'he |-> ##2 fo[1].amp_mv == AMP_500)
		else $error("hcsl amplitude wrong");
	AST_DIS_LOW:
		assert property (so[7].on && so[7].amp_mv == 0 |-> !so[7].q && so[7].qn)
		else $error("disabled output not static low");
	AST_DIV1:
		assert property ($past(fo[0].amp_mv) != 0 && fo[0].amp_mv != 0 |-> fo[0].q)
		else $error("undivided output missed a cycle");
	AST_STAT_RD:
		assert property (rd_i && addr_i == ADDR_STATUS |=> rd_data_o[STAT_BUSY_BIT] == $past(busy))
		else $error("status busy bit differs");
endmodule : fpad_align_top_chk

bind fpad_align_top fpad_align_top_chk #(.N_OUT(N_OUT), .ALIGN_LEN(ALIGN_LEN)) u_chk (
	.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i),
	.rd_i(rd_i), .rd_data_o(rd_data_o), .ref_i(ref_i),
	.fanout_clock_output_o(fanout_clock_output_o),
	.sysref_capable_output_o(sysref_capable_output_o),
	.align_busy_status_o(align_busy_status_o)
);

// file: tb/fpad_align_top_bench.sv
`timescale 1ns/10ps
module fpad_align_top_bench
	import fpad_pkg::*;
;
	logic clk_i, rst_i, wr_i, rd_i, go, busy;
	logic [ADDR_W-1:0] addr_i;
	logic [DATA_W-1:0] wr_data_i, rd_data_o;
	logic ref_w;
	fpad_drive_s [NUM_OUT-1:0] fo, so;
	int errors, tests_run;
	logic [7:0] cf[10] = '{8'h09, 8'h08, 8'h18, 8'h0c, 8'h1c, 8'h2c, 8'h3c, 8'h3e, 8'h0a, 8'h00};
	logic [13:0] ex[10] = '{{1'b0, FPAD_OFF, 11'h0}, {1'b1, FPAD_LVDS, AMP_350},
		{1'b1, FPAD_LVDS, AMP_750}, {1'b1, FPAD_LVPECL, AMP_350}, {1'b1, FPAD_LVPECL, AMP_750},
		{1'b1, FPAD_LVPECL, AMP_1000}, {1'b1, FPAD_LVPECL, AMP_1000},
		{1'b1, FPAD_HCSL, AMP_500}, {1'b1, FPAD_LVDS, AMP_350}, {1'b1, FPAD_LVDS, 11'h0}};

	// Free-running input clock, never stopped during alignment
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	fpad_align_top i_dut (
		.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i),
		.rd_i(rd_i), .rd_data_o(rd_data_o), .ref_i(ref_w), .fanout_clock_output_o(fo),
		.sysref_capable_output_o(so), .align_busy_status_o(busy)
	);
	fpad_ref_src i_src (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .ref_o(ref_w));

	////////////////////////////////////////
	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	function automatic logic [13:0] pk(input fpad_drive_s d);
		return {d.on, d.mode, d.amp_mv};
	endfunction : pk

	// Bus cycles always start on an edge, whatever time the caller left off
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wr_data_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask : wr

	task rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1;
		chk(rd_data_o, e);
	endtask : rd

	task t_reset();
		rd(ADDR_CLK_BASE, CLK_CFG_RST);
		rd(ADDR_REF_BASE + 8'h1c, REF_CFG_RST);
		rd(ADDR_STATUS, 32'h0);
		rd(8'h3c, 32'h0);
		chk({so[7].on, so[7].amp_mv, so[7].q, so[7].qn}, {1'b1, 11'h0, 2'b01});
		chk(pk(fo[7]), {1'b1, FPAD_LVDS, AMP_350});
	endtask : t_reset

	task t_decode();
		for (int i = 0; i < 10; i++) begin
			wr(ADDR_CLK_BASE + 8'h04, {24'h0, cf[i]});
			repeat (3) @(posedge clk_i);
			#1;
			chk(pk(fo[1]), ex[i]);
		end
		chk({fo[1].q, fo[1].qn}, 2'b01);
	endtask : t_decode

	task t_sysref();
		int n;
		logic b;
		wr(ADDR_REF_BASE, 32'h0000_0448);
		wr(ADDR_REF_BASE + 8'h0c, 32'h0000_0348);
		wr(ADDR_REF_BASE + 8'h14, 32'h0000_0008);
		repeat (3) @(posedge clk_i);
		#1;
		chk({so[0].ref_lead, so[3].ref_lead, so[5].ref_lead, so[5].q}, 4'b0101);
		@(posedge clk_i);
		go <= 1'b1;
		n = 0;
		b = 1'b0;
		repeat (560) begin
			@(posedge clk_i);
			go <= 1'b0;
			#1;
			n += so[3].q;
			b |= busy;
		end
		chk(n, 20);
		chk(b, 1'b0);
	endtask : t_sysref

	// Divided outputs A2 at four and B1 at two, both with no clock delay
	task t_align();
		int n, r, lp, gp;
		wr(ADDR_CLK_BASE + 8'h08, 32'h0000_0308);
		wr(ADDR_CLK_BASE + 8'h10, 32'h0000_0108);
		wr(ADDR_CTRL, 32'h1);
		rd(ADDR_STATUS, 32'h3);
		@(posedge clk_i);
		go <= 1'b1;
		n = 0;
		r = -1;
		lp = -1;
		gp = 0;
		while (busy && n < 700) begin
			@(posedge clk_i);
			go <= 1'b0;
			#1;
			n++;
			if (ref_w && r < 0) r = n;
			if (fo[2].q) begin
				if (r >= 0 && lp > r + 5 && n < r + 46) gp = n - lp;
				lp = n;
			end
		end
		chk(gp, 5);
		chk(n - r, ALIGN_CYCLES + 2);
		while (!fo[2].q && n < 800) begin
			@(posedge clk_i);
			#1;
			n++;
		end
		chk(fo[4].q, 1'b1);
		repeat (4) @(posedge clk_i);
		#1;
		chk(fo[2].q, 1'b1);
		rd(ADDR_STATUS, 32'h0);
		rd(ADDR_CTRL, 32'h0);
	endtask : t_align

	task results();
		if (errors == 0 && tests_run > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : results

	// Main sequence; the alignment is run twice to show it can be repeated
	initial begin
		rst_i = 1'b1;
		wr_i = 1'b0;
		rd_i = 1'b0;
		go = 1'b0;
		addr_i = '0;
		wr_data_i = '0;
		errors = 0;
		tests_run = 0;
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_decode();
		t_sysref();
		t_align();
		t_align();
		results();
	end

	// About three times the expected run length
	initial begin
		repeat (5000) @(posedge clk_i);
		errors++;
		results();
	end
endmodule : fpad_align_top_bench
